// ### core/rta_pkg.sv
package rta_pkg;
	localparam logic [7:0] ADDR_STATUS      = 8'h07;
	localparam logic [7:0] ADDR_INT         = 8'h08;
	localparam logic [7:0] ADDR_PWR         = 8'h09;
	localparam logic [7:0] ADDR_ALARM0      = 8'h10;
	localparam logic [7:0] ADDR_S2B0        = 8'h16;
	localparam logic [7:0] ADDR_B2S0        = 8'h1b;
	localparam int         NUM_ALARM        = 6;
	localparam int         NUM_CAP          = 5;
	localparam int         STAT_FLAG_BIT    = 0;
	localparam int         STAT_S2B_BIT     = 1;
	localparam int         INT_AUTO_CLR_BIT = 7;
	localparam int         INT_REPEAT_BIT   = 6;
	localparam int         PWR_CLR_BIT      = 0;
	localparam int         EN_BIT           = 7;
	// Index 0 seconds ... 5 weekday; date and month default to 01h
	localparam logic [5:0][7:0] ALARM_RST   = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam int         CLK_MHZ          = 100;
	localparam int         IRQ_PULSE_US     = 250000;
	localparam int         IRQ_PULSE_CYC    = IRQ_PULSE_US * CLK_MHZ;

	typedef enum logic [1:0] {
		RTA_MODE_OFF    = 2'b00,
		RTA_MODE_SINGLE = 2'b01,
		RTA_MODE_REPEAT = 2'b10,
		RTA_MODE_FREQ   = 2'b11
	} rta_mode_t;
endpackage

// ### core/rta_match_if.sv
`timescale 1ns/10ps
// Alarm settings and current time into the comparator, verdict back
interface rta_match_if;
	logic [5:0][7:0] alarm;
	logic [5:0][7:0] now;
	logic            hit;
	logic            any_en;
	modport matcher (input alarm, input now, output hit, output any_en);
	modport owner   (output alarm, output now, input hit, input any_en);
endinterface

// ### core/rta_matcher.sv
`timescale 1ns/10ps
module rta_matcher (
	rta_match_if.matcher m
);
	logic [5:0] fld_ok;
	logic [5:0] fld_en;

	// Per field: enable in bit 7, BCD value below it
	for (genvar g = 0; g < rta_pkg::NUM_ALARM; g++) begin : g_fld
		assign fld_en[g] = m.alarm[g][rta_pkg::EN_BIT];
		assign fld_ok[g] = !fld_en[g] || (m.alarm[g][6:0] == m.now[g][6:0]);
	end

	assign m.any_en = |fld_en;
	assign m.hit    = (&fld_ok) && m.any_en;
endmodule // rta_matcher

// ### core/rta_alarm_stamp.sv
`timescale 1ns/10ps
module rta_alarm_stamp #(
	parameter int unsigned PULSE_CYCLES = rta_pkg::IRQ_PULSE_CYC
) (
	input  wire logic       I_CLOCK,
	input  wire logic       I_RESETN,
	input  wire logic [7:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	input  wire logic       I_TICK,
	input  wire logic [7:0] I_SEC,
	input  wire logic [7:0] I_MIN,
	input  wire logic [7:0] I_HOUR,
	input  wire logic [7:0] I_DATE,
	input  wire logic [7:0] I_MONTH,
	input  wire logic [7:0] I_WDAY,
	input  wire logic       I_ON_BATTERY,
	input  wire logic       I_FREQ_ON,
	input  wire logic       I_FREQ_WAVE,
	output logic            O_IRQ_OR_FREQ_OUT_O,
	output logic            O_IRQ_OR_FREQ_OUT_OE
);
	rta_match_if m ();

	logic [5:0][7:0]    alarm_r;
	logic [4:0][7:0]    s2b_r;
	logic [4:0][7:0]    b2s_r;
	logic               s2b_valid_r;
	logic               auto_clr_r;
	logic               repeat_sel_r;
	logic               flag_r;
	logic               flag_nxt;
	logic               single_done_r;
	logic [31:0]        cnt_r;
	logic               oe_r;
	logic               oe_nxt;
	logic [7:0]         rdata_r;
	logic [7:0]         rdata_nxt;
	logic               bat_d_r;
	rta_pkg::rta_mode_t mode;
	logic               wr_status;
	logic               rd_status;
	logic               wr_alarm;
	logic               wr_int;
	logic               clr_stamp;
	logic               match_ev;
	logic               take_ev;
	logic               to_bat;
	logic               to_sup;
	logic [2:0]         a_idx;
	logic [2:0]         s_idx;
	logic [2:0]         b_idx;

	rta_matcher u_match (
		.m (m.matcher)
	);

	assign m.alarm = alarm_r;
	assign m.now   = {I_WDAY, I_MONTH, I_DATE, I_HOUR, I_MIN, I_SEC};

	// Register strobes and bank indices
	assign wr_status = I_WR && (I_ADDR == rta_pkg::ADDR_STATUS);
	assign rd_status = I_RD && (I_ADDR == rta_pkg::ADDR_STATUS);
	assign wr_int    = I_WR && (I_ADDR == rta_pkg::ADDR_INT);
	assign wr_alarm  = I_WR && (I_ADDR >= rta_pkg::ADDR_ALARM0) && (I_ADDR < rta_pkg::ADDR_S2B0);
	assign clr_stamp = I_WR && (I_ADDR == rta_pkg::ADDR_PWR) && I_WDATA[rta_pkg::PWR_CLR_BIT];
	assign a_idx     = 3'(I_ADDR - rta_pkg::ADDR_ALARM0);
	assign s_idx     = 3'(I_ADDR - rta_pkg::ADDR_S2B0);
	assign b_idx     = 3'(I_ADDR - rta_pkg::ADDR_B2S0);

	// Operating mode; frequency output overrides both alarm modes
	always_comb begin
		if (I_FREQ_ON) begin
			mode = rta_pkg::RTA_MODE_FREQ;
		end else if (m.any_en && repeat_sel_r) begin
			mode = rta_pkg::RTA_MODE_REPEAT;
		end else if (m.any_en) begin
			mode = rta_pkg::RTA_MODE_SINGLE;
		end else begin
			mode = rta_pkg::RTA_MODE_OFF;
		end
	end

	// compare on the tick that brings the new time
	assign match_ev = I_TICK && m.hit;
	// single mode accepts one match until re-armed
	assign take_ev  = match_ev && !((mode == rta_pkg::RTA_MODE_SINGLE) && single_done_r);

	// Alarm bytes; written as is, BCD with enable on top
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			alarm_r <= rta_pkg::ALARM_RST;
		end else if (wr_alarm) begin
			alarm_r[a_idx] <= I_WDATA;
		end
	end

	// Interrupt control register
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			auto_clr_r   <= 1'b0;
			repeat_sel_r <= 1'b0;
		end else if (wr_int) begin
			auto_clr_r   <= I_WDATA[rta_pkg::INT_AUTO_CLR_BIT];
			repeat_sel_r <= I_WDATA[rta_pkg::INT_REPEAT_BIT];
		end
	end

	// Alarm flag; a match in the clearing cycle still lands
	always_comb begin
		flag_nxt = flag_r;
		if (wr_status && !I_WDATA[rta_pkg::STAT_FLAG_BIT]) begin
			flag_nxt = 1'b0;
		end
		if (rd_status && auto_clr_r) begin
			flag_nxt = 1'b0;
		end
		if (take_ev) begin
			flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// Single-shot lockout, re-armed by reprogramming the alarm or mode
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			single_done_r <= 1'b0;
		end else if (take_ev && (mode == rta_pkg::RTA_MODE_SINGLE)) begin
			single_done_r <= 1'b1;
		end else if (wr_alarm || wr_int) begin
			single_done_r <= 1'b0;
		end
	end

	// Pulse width counter; a new match restarts the full width
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cnt_r <= 32'h0000_0000;
		end else if (take_ev && (mode == rta_pkg::RTA_MODE_REPEAT)) begin
			cnt_r <= PULSE_CYCLES;
		end else if (cnt_r != 32'h0000_0000) begin
			cnt_r <= cnt_r - 32'h0000_0001;
		end
	end

	// Pin drive, open drain: enable high pulls the line low
	always_comb begin
		case (mode)
			rta_pkg::RTA_MODE_FREQ:   oe_nxt = !I_FREQ_WAVE;
			rta_pkg::RTA_MODE_SINGLE: oe_nxt = flag_r;
			rta_pkg::RTA_MODE_REPEAT: oe_nxt = (cnt_r != 32'h0000_0000);
			default:                  oe_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= oe_nxt;
		end
	end

	assign O_IRQ_OR_FREQ_OUT_O  = 1'b0;
	assign O_IRQ_OR_FREQ_OUT_OE = oe_r;

	// Power source edge detect; input already synchronous
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			bat_d_r <= 1'b0;
		end else begin
			bat_d_r <= I_ON_BATTERY;
		end
	end

	assign to_bat = I_ON_BATTERY && !bat_d_r;
	assign to_sup = !I_ON_BATTERY && bat_d_r;

	// Supply-to-battery bank; capture beats a same-cycle clear
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			s2b_r       <= '0;
			s2b_valid_r <= 1'b0;
		end else if (to_bat && !s2b_valid_r) begin
			s2b_r       <= m.now[4:0];
			s2b_valid_r <= 1'b1;
		end else if (clr_stamp) begin
			s2b_r       <= '0;
			s2b_valid_r <= 1'b0;
		end
	end

	// Battery-to-supply bank
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			b2s_r <= '0;
		end else if (to_sup) begin
			b2s_r <= m.now[4:0];
		end else if (clr_stamp) begin
			b2s_r <= '0;
		end
	end

	// Read mux; unmapped addresses read 00h
	always_comb begin
		rdata_nxt = 8'h00;
		if (I_ADDR == rta_pkg::ADDR_STATUS) begin
			rdata_nxt[rta_pkg::STAT_FLAG_BIT] = flag_r;
			rdata_nxt[rta_pkg::STAT_S2B_BIT]  = s2b_valid_r;
		end else if (I_ADDR == rta_pkg::ADDR_INT) begin
			rdata_nxt[rta_pkg::INT_AUTO_CLR_BIT] = auto_clr_r;
			rdata_nxt[rta_pkg::INT_REPEAT_BIT]   = repeat_sel_r;
		end else if (I_ADDR >= rta_pkg::ADDR_ALARM0 && I_ADDR < rta_pkg::ADDR_S2B0) begin
			rdata_nxt = alarm_r[a_idx];
		end else if (I_ADDR >= rta_pkg::ADDR_S2B0 && I_ADDR < rta_pkg::ADDR_B2S0) begin
			rdata_nxt = s2b_r[s_idx];
		end else if (I_ADDR >= rta_pkg::ADDR_B2S0 && I_ADDR < 8'h20) begin
			rdata_nxt = b2s_r[b_idx];
		end
	end

	// Read data holds until the next read
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rdata_r <= 8'h00;
		end else if (I_RD) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign O_RDATA = rdata_r;

	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RESETN);

	no_enable_a: assert property (!m.any_en |-> !m.hit)
		else $error("match reported with no field enabled");

	match_flag_a: assert property (take_ev |=> flag_r)
		else $error("accepted match did not set alarm flag");

	single_low_a: assert property ((take_ev && mode == rta_pkg::RTA_MODE_SINGLE
		&& !I_FREQ_ON) ##1 (mode == rta_pkg::RTA_MODE_SINGLE) |=> oe_r)
		else $error("single alarm did not pull pin low");

	single_once_a: assert property ((mode == rta_pkg::RTA_MODE_SINGLE) && single_done_r && !flag_r
		&& !I_WR |=> !flag_r)
		else $error("second single-mode match accepted");

	repeat_pulse_a: assert property ((take_ev && mode == rta_pkg::RTA_MODE_REPEAT)
		##1 (mode == rta_pkg::RTA_MODE_REPEAT)[*8] |-> ##1 oe_r)
		else $error("repeat alarm pulse missing");

	host_clear_a: assert property (wr_status && !I_WDATA[rta_pkg::STAT_FLAG_BIT] && !take_ev
		|=> !flag_r)
		else $error("flag survived host clear");

	auto_clear_a: assert property (rd_status && auto_clr_r && !take_ev |=> !flag_r)
		else $error("flag survived auto clear read");

	first_only_a: assert property (s2b_valid_r && !clr_stamp |=> $stable(s2b_r))
		else $error("supply-to-battery bank overwritten");

	last_kept_a: assert property (to_sup |=> b2s_r == $past(m.now[4:0]))
		else $error("battery-to-supply bank not updated");

	stamp_clear_a: assert property (clr_stamp && !to_bat && !to_sup
		|=> (s2b_r == '0) && (b2s_r == '0))
		else $error("capture banks not zero after clear");

	freq_pin_a: assert property (mode == rta_pkg::RTA_MODE_FREQ
		|=> oe_r == !$past(I_FREQ_WAVE))
		else $error("alarm disturbed frequency output");
endmodule // rta_alarm_stamp

// ### testbench/rta_host.sv
`timescale 1ns/10ps
// Host model driving the byte register port
module rta_host (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rdata,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	// Idle bus, address parked off the map
	initial begin
		o_addr = 8'hff;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// Write strobe held for one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clock);
		o_addr <= a;
		o_wdata <= v;
		o_wr <= 1'b1;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_wdata <= ~v; // Stale data must not look valid
	endtask
	// Read data is registered and holds, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge i_clock);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clock);
		o_rd <= 1'b0;
		@(posedge i_clock);
		v = i_rdata;
	endtask
	task automatic clr_flag();
		wr(rta_pkg::ADDR_STATUS, 8'h00);
	endtask
	task automatic clr_cap();
		wr(rta_pkg::ADDR_PWR, 8'h01);
	endtask
endmodule // rta_host

// ### testbench/rtc_alarm_and_power_timestamp_tb.sv
`timescale 1ns/10ps
// Bench for alarm matching and power time stamps
module rtc_alarm_and_power_timestamp_tb;
	localparam int P = 20;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            tick = 1'b0;
	logic            bat = 1'b0;
	logic            fon = 1'b0;
	logic            wave = 1'b0;
	logic [5:0][7:0] tm = '0;
	logic [5:0][7:0] a, t, s2b, b2s;
	logic [7:0]      addr, wdata, rdata, d;
	logic            wr, rd, oe, od, pin, h, fl;
	int              num_errors = 0;
	int              total_checks = 0;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;
	// Open-drain pin with pull-up
	assign pin = oe ? od : 1'b1;

	rta_alarm_stamp #(.PULSE_CYCLES(P)) rta_alarm_stamp_inst (
		.I_CLOCK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TICK(tick),
		.I_SEC(tm[0]), .I_MIN(tm[1]), .I_HOUR(tm[2]), .I_DATE(tm[3]),
		.I_MONTH(tm[4]), .I_WDAY(tm[5]), .I_ON_BATTERY(bat), .I_FREQ_ON(fon),
		.I_FREQ_WAVE(wave), .O_IRQ_OR_FREQ_OUT_O(od), .O_IRQ_OR_FREQ_OUT_OE(oe));
	rta_host rta_host_inst (.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic pchk(input logic e);
		chk({7'h00, pin}, {7'h00, e});
	endtask
	task automatic st(input logic [7:0] e);
		rta_host_inst.rd(rta_pkg::ADDR_STATUS, d);
		chk(d, e);
	endtask
	// Only bits 6:0 of enabled fields take part
	function automatic logic exp_hit(input logic [47:0] al, input logic [47:0] tv);
		logic en, mis;
		en = 1'b0;
		mis = 1'b0;
		for (int i = 0; i < 6; i++) begin
			en |= al[8*i+7];
			mis |= al[8*i+7] && (al[8*i+:7] != tv[8*i+:7]);
		end
		return en && !mis;
	endfunction
	function automatic logic [47:0] rnd48();
		return {16'($urandom), $urandom};
	endfunction
	task automatic set_al(input logic [5:0][7:0] v);
		for (int i = 0; i < 6; i++) begin
			rta_host_inst.wr(rta_pkg::ADDR_ALARM0 + 8'(i), v[i]);
		end
	endtask
	// One-second tick; returns settled two edges after it is taken
	task automatic step(input logic [47:0] v);
		@(posedge clk);
		tm <= v;
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic stop_test();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog: the run needs under a thousand cycles
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end

	// Main sequence
	initial begin
		d = 8'($urandom(58));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			rta_host_inst.rd(rta_pkg::ADDR_ALARM0 + 8'(i), d);
			chk(d, (i < 6) ? rta_pkg::ALARM_RST[i] : 8'h00);
		end
		rta_host_inst.rd(8'h30, d);
		chk(d, 8'h00);
		$display("test reset done");
		// Single event at 11:30 Jan 1, seconds and weekday ignored
		set_al({8'h00, 8'h81, 8'h81, 8'h91, 8'hb0, 8'h00});
		step({8'h03, 8'h01, 8'h01, 8'h11, 8'h29, 8'h59});
		pchk(1'b1);
		step({8'h03, 8'h01, 8'h01, 8'h11, 8'h30, 8'h00});
		pchk(1'b0);
		st(8'h01);
		rta_host_inst.clr_flag();
		repeat (2) @(posedge clk);
		#1 pchk(1'b1);
		step({8'h05, 8'h01, 8'h01, 8'h11, 8'h30, 8'h15});
		pchk(1'b1);
		st(8'h00);
		rta_host_inst.wr(rta_pkg::ADDR_INT, 8'h80);
		step({8'h04, 8'h01, 8'h01, 8'h11, 8'h30, 8'h07});
		pchk(1'b0);
		st(8'h01);
		st(8'h00);
		#1 pchk(1'b1);
		$display("test single done");
		// Repeat mode: random fields, flag left set between pulses
		rta_host_inst.wr(rta_pkg::ADDR_INT, 8'h40);
		fl = 1'b0;
		for (int n = 0; n < 12; n++) begin
			for (int i = 0; i < 6; i++) begin
				a[i] = 8'($urandom);
				t[i] = ($urandom % 2) ? {1'b0, a[i][6:0]} : 8'($urandom);
			end
			if (n == 0) a = {40'h0, 8'hb0};
			if (n == 0) t[0] = 8'h30;
			if (n == 1) a &= {6{8'h7f}};
			h = exp_hit(a, t);
			fl |= h;
			set_al(a);
			step(t);
			pchk(!h);
			repeat (P - 2) @(posedge clk);
			#1 pchk(!h);
			// Pulse is exactly P cycles, so the very next edge releases it
			@(posedge clk);
			#1 pchk(1'b1);
			st({7'h00, fl});
		end
		$display("test repeat done");
		// Frequency output owns the pin; the wave is left high so an alarm pull would show
		rta_host_inst.clr_flag();
		fon <= 1'b1;
		for (int n = 0; n < 6; n++) begin
			@(posedge clk);
			wave <= n[0];
			@(posedge clk);
			#1 pchk(n[0]);
		end
		set_al({40'h0, 8'hb0});
		step({40'h0, 8'h30});
		pchk(1'b1);
		st(8'h01);
		fon <= 1'b0;
		rta_host_inst.clr_flag();
		$display("test freq done");
		// Supply-to-battery keeps the first stamp, the other the last
		s2b = '0;
		b2s = '0;
		for (int n = 0; n < 4; n++) begin
			@(posedge clk);
			tm <= rnd48();
			bat <= !bat;
			repeat (3) @(posedge clk);
			if (n == 0) s2b = tm;
			if (n[0]) b2s = tm;
			for (int i = 0; i < 5; i++) begin
				rta_host_inst.rd(rta_pkg::ADDR_S2B0 + 8'(i), d);
				chk(d, s2b[i]);
				rta_host_inst.rd(rta_pkg::ADDR_B2S0 + 8'(i), d);
				chk(d, b2s[i]);
			end
		end
		st(8'h02);
		rta_host_inst.clr_cap();
		for (int i = 0; i < 10; i++) begin
			rta_host_inst.rd(rta_pkg::ADDR_S2B0 + 8'(i), d);
			chk(d, 8'h00);
		end
		rta_host_inst.rd(rta_pkg::ADDR_PWR, d);
		chk(d, 8'h00);
		st(8'h00);
		$display("test capture done");
		stop_test();
	end
endmodule // rtc_alarm_and_power_timestamp_tb
